//--- rtl/gpio_pkg.sv
// Package with constants and carrier structs for the octal I/O port
package gpio_pkg;
  localparam int unsigned PORT_WIDTH = 8;
  localparam logic [7:0] DIRECTION_RESET = 8'hff;
  localparam logic [7:0] ANALOG_RESET = 8'hff;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam int unsigned PIN_SPI_CLOCK = 0;
  localparam int unsigned PIN_CAPTURE_COMPARE_CH4 = 1;
  localparam int unsigned PIN_PWM2_OUT2 = 2;
  localparam int unsigned PIN_PWM2_OUT4 = 3;
  localparam int unsigned PIN_PWM2_OUT3 = 4;
  localparam int unsigned PIN_PWM1_OUT2 = 5;
  localparam int unsigned PIN_PWM1_OUT3 = 6;
  localparam int unsigned PIN_PWM1_OUT4 = 7;
  localparam int unsigned ANALOG_PINS = 6;

  // One peripheral output request: enable plus level
  typedef struct packed {
    logic en;
    logic val;
  } periph_out_s;

  // Peripheral outputs that may claim port pins
  typedef struct packed {
    periph_out_s spi2_clock;
    periph_out_s i2c2_clock;
    periph_out_s capture_compare_ch4;
    periph_out_s i2c2_data;
    periph_out_s pwm_ch2_out2;
    periph_out_s pwm_ch2_out4;
    periph_out_s pwm_ch2_out3;
    periph_out_s spi2_data_out;
    periph_out_s pwm_ch1_out2;
    periph_out_s pwm_ch1_out3;
    periph_out_s serial2_transmit;
    periph_out_s pwm_ch1_out4;
    periph_out_s serial2_receive;
  } periph_outs_s;

  // Digital inputs routed to peripherals
  typedef struct packed {
    logic spi2_clock;
    logic i2c2_clock;
    logic capture_compare_ch4;
    logic spi2_data_in;
    logic i2c2_data;
    logic spi2_slave_select;
    logic serial2_clock;
    logic serial2_receive;
  } periph_ins_s;

  // Complete register state of the port
  typedef struct packed {
    logic [7:0] port_direction;
    logic [7:0] port_output_latch;
    logic [7:0] port_analog_select;
    logic [7:0] sync1;
    logic [7:0] port_pin_state;
  } port_state_s;
endpackage : gpio_pkg

//--- rtl/octal_gpio_port_with_pin_mux.sv
// Octal bidirectional I/O port with peripheral pin multiplexing
// Usage notes:
// Direction, not analog select, decides whether a pin is driven, so keep
// analog pins as inputs. Pin-state reads lag the pads by two clocks
// through the synchroniser. Peripheral enables choose only the driven
// level; the direction bit must still be cleared for a peripheral to
// reach its pin.
module octal_gpio_port_with_pin_mux
#(
  parameter int unsigned WIDTH = gpio_pkg::PORT_WIDTH
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] wdata, // Register write data
  input wire logic direction_we, // Write strobe for direction
  input wire logic latch_we, // Write strobe for output latch
  input wire logic pin_state_we, // Write strobe for pin state
  input wire logic analog_we, // Write strobe for analog select
  input wire logic pwm2b_location_select, // Configuration bit
  output logic [7:0] port_direction, // Direction readback
  output logic [7:0] port_output_latch, // Latch readback
  output logic [7:0] port_pin_state, // Synchronized pin levels
  output logic [7:0] port_analog_select, // Analog select readback
  input wire gpio_pkg::periph_outs_s periph_out, // Peripheral drives
  output gpio_pkg::periph_ins_s periph_in, // Peripheral inputs
  output logic [5:0] analog_channel_enable, // Channels 20 to 25
  input wire logic [7:0] pin_in, // Pin levels from pads
  output logic [7:0] pin_out, // Pin output levels
  output logic [7:0] pin_oe // Pin output enables
);
  import gpio_pkg::*;

  // Whole register state of the port and its next value
  port_state_s state_q;
  port_state_s state_d;
  // Per-pin claim by a peripheral: enable and the level it wants
  logic [7:0] periph_en;
  logic [7:0] periph_val;
  // Synchronised pin levels after analog blanking
  logic [7:0] dig_in;

  // Register updates; each direction bit stands alone
  always_comb begin
    state_d = state_q;
    if (direction_we) begin
      state_d.port_direction = wdata;
    end
    // Both the latch and the pin-state address load the latch, so a
    // read-modify-write through the pin-state address copies pin levels into it
    if (latch_we || pin_state_we) begin
      state_d.port_output_latch = wdata;
    end
    if (analog_we) begin
      state_d.port_analog_select = wdata;
    end
    // Two-stage synchroniser: only the second stage reads the first, so
    // a metastable first stage never reaches the blanking gates; the
    // second stage keeps the raw levels and blanking follows it
    state_d.sync1 = pin_in;
    state_d.port_pin_state = state_q.sync1;
  end

  // State register with power-on defaults
  // Every pin comes up an analog input with its driver off; the latch is
  // cleared so the first direction change drives a known level, and the
  // synchroniser starts at zero so no stale level reaches a peripheral
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q.port_direction <= DIRECTION_RESET;
      state_q.port_analog_select <= ANALOG_RESET;
      state_q.port_output_latch <= LATCH_RESET;
      state_q.sync1 <= 8'h00;
      state_q.port_pin_state <= 8'h00;
    end else begin
      state_q <= state_d;
    end
  end

  // Fixed priority per pin; first listed wins
  // Output owners per pin, highest first, latch last:
  //   pin 0: SPI clock, I2C clock
  //   pin 1: compare/PWM 4, I2C data
  //   pin 2: PWM2 output 2, alternate location only
  //   pin 3: PWM2 output 4
  //   pin 4: PWM2 output 3, SPI data out
  //   pin 5: PWM1 output 2
  //   pin 6: PWM1 output 3, serial transmit or clock
  //   pin 7: PWM1 output 4, serial synchronous data
  // Claims never touch the output enable
  always_comb begin
    periph_en = 8'h00;
    periph_val = 8'h00;
    // Pin 0: serial port 2 clock, SPI before I2C
    if (periph_out.spi2_clock.en) begin
      periph_en[PIN_SPI_CLOCK] = 1'b1;
      periph_val[PIN_SPI_CLOCK] = periph_out.spi2_clock.val;
    end else if (periph_out.i2c2_clock.en) begin
      periph_en[PIN_SPI_CLOCK] = 1'b1;
      periph_val[PIN_SPI_CLOCK] = periph_out.i2c2_clock.val;
    end
    // Pin 1: compare output, then I2C data
    if (periph_out.capture_compare_ch4.en) begin
      periph_en[PIN_CAPTURE_COMPARE_CH4] = 1'b1;
      periph_val[PIN_CAPTURE_COMPARE_CH4] = periph_out.capture_compare_ch4.val;
    end else if (periph_out.i2c2_data.en) begin
      periph_en[PIN_CAPTURE_COMPARE_CH4] = 1'b1;
      periph_val[PIN_CAPTURE_COMPARE_CH4] = periph_out.i2c2_data.val;
    end
    // Pin 2: alternate PWM2 output 2 location
    if (periph_out.pwm_ch2_out2.en && !pwm2b_location_select) begin
      periph_en[PIN_PWM2_OUT2] = 1'b1;
      periph_val[PIN_PWM2_OUT2] = periph_out.pwm_ch2_out2.val;
    end
    // Pin 3
    if (periph_out.pwm_ch2_out4.en) begin
      periph_en[PIN_PWM2_OUT4] = 1'b1;
      periph_val[PIN_PWM2_OUT4] = periph_out.pwm_ch2_out4.val;
    end
    // Pin 4: PWM before SPI data out
    if (periph_out.pwm_ch2_out3.en) begin
      periph_en[PIN_PWM2_OUT3] = 1'b1;
      periph_val[PIN_PWM2_OUT3] = periph_out.pwm_ch2_out3.val;
    end else if (periph_out.spi2_data_out.en) begin
      periph_en[PIN_PWM2_OUT3] = 1'b1;
      periph_val[PIN_PWM2_OUT3] = periph_out.spi2_data_out.val;
    end
    // Pin 5
    if (periph_out.pwm_ch1_out2.en) begin
      periph_en[PIN_PWM1_OUT2] = 1'b1;
      periph_val[PIN_PWM1_OUT2] = periph_out.pwm_ch1_out2.val;
    end
    // Pin 6: PWM then serial transmit/clock
    if (periph_out.pwm_ch1_out3.en) begin
      periph_en[PIN_PWM1_OUT3] = 1'b1;
      periph_val[PIN_PWM1_OUT3] = periph_out.pwm_ch1_out3.val;
    end else if (periph_out.serial2_transmit.en) begin
      periph_en[PIN_PWM1_OUT3] = 1'b1;
      periph_val[PIN_PWM1_OUT3] = periph_out.serial2_transmit.val;
    end
    // Pin 7: PWM then serial synchronous data
    if (periph_out.pwm_ch1_out4.en) begin
      periph_en[PIN_PWM1_OUT4] = 1'b1;
      periph_val[PIN_PWM1_OUT4] = periph_out.pwm_ch1_out4.val;
    end else if (periph_out.serial2_receive.en) begin
      periph_en[PIN_PWM1_OUT4] = 1'b1;
      periph_val[PIN_PWM1_OUT4] = periph_out.serial2_receive.val;
    end
  end

  // Per-pin driver; analog select does not gate outputs
  // The enable follows direction alone; a peripheral claim only swaps the
  // level that the latch would otherwise put out
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    assign pin_oe[i] = ~state_q.port_direction[i];
    assign pin_out[i] = periph_en[i] ? periph_val[i]
                                     : state_q.port_output_latch[i];
  end

  // Analog channel connection for pins 0 to 5
  // Pins 6 and 7 have no channel output on this port
  for (genvar a = 0; a < ANALOG_PINS; a++) begin : g_analog
    assign analog_channel_enable[a] = state_q.port_direction[a] &
                                      state_q.port_analog_select[a];
  end

  // Digital inputs to peripherals, blanked in analog mode
  // Blanking after the synchroniser means an analog pin reads zero in the
  // same cycle that its select bit is set
  assign dig_in = state_q.port_pin_state & ~state_q.port_analog_select;
  // Pin 0 clock feeds both serial modes; pin 1 feeds capture and data
  assign periph_in.spi2_clock = dig_in[PIN_SPI_CLOCK];
  assign periph_in.i2c2_clock = dig_in[PIN_SPI_CLOCK];
  assign periph_in.capture_compare_ch4 = dig_in[PIN_CAPTURE_COMPARE_CH4];
  assign periph_in.spi2_data_in = dig_in[PIN_CAPTURE_COMPARE_CH4];
  assign periph_in.i2c2_data = dig_in[PIN_CAPTURE_COMPARE_CH4];
  assign periph_in.spi2_slave_select = dig_in[PIN_PWM2_OUT4];
  assign periph_in.serial2_clock = dig_in[PIN_PWM1_OUT3];
  assign periph_in.serial2_receive = dig_in[PIN_PWM1_OUT4];

  // Register readback
  // The latch reads back on its own, never the pin levels
  assign port_direction = state_q.port_direction;
  assign port_output_latch = state_q.port_output_latch;
  assign port_pin_state = dig_in;
  assign port_analog_select = state_q.port_analog_select;
endmodule : octal_gpio_port_with_pin_mux

//--- test/gpio_port_checker_assertions.sv
// Checker for the octal port's registers, pin drivers and inputs
module gpio_port_checker
  import gpio_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] wdata, // Write data
  input wire logic latch_we, // Latch strobe
  input wire logic pin_state_we, // Pin-state strobe
  input wire logic pwm2b_location_select, // Location bit
  input wire gpio_pkg::periph_outs_s periph_out, // Peripheral drives
  input wire logic [7:0] port_direction, // Direction
  input wire logic [7:0] port_output_latch, // Latch
  input wire logic [7:0] port_pin_state, // Pin state
  input wire logic [7:0] port_analog_select, // Analog select
  input wire logic [5:0] analog_channel_enable, // Channels
  input wire logic [7:0] pin_in, // Pad levels
  input wire logic [7:0] pin_out, // Pin levels
  input wire logic [7:0] pin_oe // Enables
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Driver, register and routing relations
  property p_oe;
    pin_oe == ~port_direction;
  endproperty
  a_oe: assert property (p_oe) else $error("oe mismatch");
  property p_lat;
    latch_we || pin_state_we |=> port_output_latch == $past(wdata);
  endproperty
  a_lat: assert property (p_lat) else $error("latch write lost");
  property p_rst;
    $fell(rst) |-> port_direction == 8'hff &&
      port_analog_select == 8'hff && port_output_latch == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_ana;
    analog_channel_enable ==
      (port_direction[5:0] & port_analog_select[5:0]);
  endproperty
  a_ana: assert property (p_ana) else $error("analog enable wrong");
  property p_pin;
    !$past(rst) && !$past(rst, 2) && $stable(port_analog_select) &&
      $past(port_analog_select, 2) == port_analog_select
      |-> port_pin_state == ($past(pin_in, 2) & ~port_analog_select);
  endproperty
  a_pin: assert property (p_pin) else $error("pin state wrong");
  property p_pin0;
    periph_out.spi2_clock.en |-> pin_out[0] == periph_out.spi2_clock.val;
  endproperty
  a_pin0: assert property (p_pin0) else $error("pin 0 owner wrong");
  property p_pin5;
    pin_out[5] == (periph_out.pwm_ch1_out2.en ? periph_out.pwm_ch1_out2.val
      : port_output_latch[5]);
  endproperty
  a_pin5: assert property (p_pin5) else $error("pin 5 wrong");
  property p_pin2;
    pin_out[2] == (!pwm2b_location_select && periph_out.pwm_ch2_out2.en
      ? periph_out.pwm_ch2_out2.val : port_output_latch[2]);
  endproperty
  a_pin2: assert property (p_pin2) else $error("pin 2 wrong");
  property p_pin4;
    pin_out[4] == (periph_out.pwm_ch2_out3.en ? periph_out.pwm_ch2_out3.val
      : periph_out.spi2_data_out.en ? periph_out.spi2_data_out.val
      : port_output_latch[4]);
  endproperty
  a_pin4: assert property (p_pin4) else $error("pin 4 wrong");
  c_wr: cover property (latch_we);
  c_pri: cover property (periph_out.spi2_clock.en && periph_out.i2c2_clock.en);
  c_loc: cover property (pwm2b_location_select && periph_out.pwm_ch2_out2.en);
endmodule : gpio_port_checker
bind octal_gpio_port_with_pin_mux gpio_port_checker u_gpio_port_checker (
  .clk(clk),
  .rst(rst),
  .wdata(wdata),
  .latch_we(latch_we),
  .pin_state_we(pin_state_we),
  .pwm2b_location_select(pwm2b_location_select),
  .periph_out(periph_out),
  .port_direction(port_direction),
  .port_output_latch(port_output_latch),
  .port_pin_state(port_pin_state),
  .port_analog_select(port_analog_select),
  .analog_channel_enable(analog_channel_enable),
  .pin_in(pin_in),
  .pin_out(pin_out),
  .pin_oe(pin_oe)
);

//--- test/pad_model.sv
// Pad model resolving each pin from the port driver or the outside level
module pad_model (
  input wire logic [7:0] pin_out, // Port output levels
  input wire logic [7:0] pin_oe, // Port output enables
  input wire logic [7:0] ext_level, // Level applied from outside
  output logic [7:0] pin_in // Resolved pad levels
);
  timeunit 1ns;
  timeprecision 1ns;
  // Driven pins read their own level, released pins the outside one
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pad_model

//--- test/testbench.sv
// Self-checking bench for the octal port
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import gpio_pkg::*;
  typedef struct packed {logic [7:0] d, l, a, e, ps, ac, r;} row_s;
  logic clk, rst, loc;
  logic [3:0] we;
  logic [7:0] wdata, ext, pin_in, pin_out, pin_oe, dir, lat, ps, ana;
  logic [5:0] ach;
  periph_outs_s po;
  periph_ins_s pi;
  int miscompares, total_checks;
  // Field r: peripheral inputs in struct order, routed from pin state
  row_s rows[4] = '{'{8'hff, 8'h00, 8'h00, 8'ha5, 8'ha5, 8'h00, 8'hc1},
    '{8'h00, 8'h3c, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h3f, 8'hc0, 8'h0f, 8'h55, 8'hd0, 8'h0f, 8'h03},
    '{8'hf0, 8'h0a, 8'h3c, 8'h81, 8'h82, 8'h30, 8'h39}};
  octal_gpio_port_with_pin_mux u_octal_gpio_port_with_pin_mux (
    .clk(clk),
    .rst(rst),
    .wdata(wdata),
    .direction_we(we[0]),
    .latch_we(we[1]),
    .pin_state_we(we[2]),
    .analog_we(we[3]),
    .pwm2b_location_select(loc),
    .port_direction(dir),
    .port_output_latch(lat),
    .port_pin_state(ps),
    .port_analog_select(ana),
    .periph_out(po),
    .periph_in(pi),
    .analog_channel_enable(ach),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );
  pad_model u_pad_model (
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .ext_level(ext),
    .pin_in(pin_in)
  );
  task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  // Strobe k raised at an edge and held until the next call or idle
  task wr(input int k, input logic [7:0] v);
    @(posedge clk);
    we <= 4'(1 << k);
    wdata <= v;
  endtask : wr
  task idle();
    @(posedge clk);
    we <= 4'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask : idle
  task complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #20000;
    miscompares++;
    complete_run();
  end
  // Reset, table rows, then priority and back-to-back writes
  initial begin
    rst = 1'b1;
    loc = 1'b0;
    we = 4'h0;
    wdata = 8'h00;
    ext = 8'h00;
    po = '0;
    miscompares = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("dir", dir, 8'hff);
    chk("ana", ana, 8'hff);
    chk("oe", pin_oe, 8'h00);
    chk("ach", {2'b0, ach}, 8'h3f);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(1, rows[i].l);
      ext <= rows[i].e;
      wr(3, rows[i].a);
      wr(0, rows[i].d);
      idle();
      chk("oe", pin_oe, ~rows[i].d);
      chk("out", pin_out, rows[i].l);
      chk("state", ps, rows[i].ps);
      chk("ach", {2'b0, ach}, rows[i].ac);
      chk("route", pi, rows[i].r);
    end
    $display("row tests done");
    @(posedge clk);
    po.spi2_clock <= 2'b11;
    po.i2c2_clock <= 2'b10;
    po.capture_compare_ch4 <= 2'b10;
    po.i2c2_data <= 2'b11;
    po.pwm_ch2_out2 <= 2'b11;
    #1;
    chk("pri", pin_out & 8'h07, 8'h05);
    @(posedge clk);
    loc <= 1'b1;
    #1;
    chk("loc", pin_out & 8'h07, 8'h01);
    wr(1, 8'haa);
    wr(2, 8'h55);
    idle();
    chk("b2b", lat, 8'h55);
    $display("priority tests done");
    // Second reset in mid-run while the remaining owners except PWM1 output 4 are switched on
    @(posedge clk);
    rst <= 1'b1;
    po.pwm_ch2_out4 <= 2'b11;
    po.pwm_ch2_out3 <= 2'b10;
    po.spi2_data_out <= 2'b11;
    po.pwm_ch1_out2 <= 2'b11;
    po.pwm_ch1_out3 <= 2'b10;
    po.serial2_transmit <= 2'b11;
    po.serial2_receive <= 2'b11;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("rst_dir", dir, 8'hff);
    chk("rst_ana", ana, 8'hff);
    chk("rst_lat", lat, 8'h00);
    chk("rst_oe", pin_oe, 8'h00);
    $display("second reset test done");
    // All pins driven while still in analog mode
    wr(0, 8'h00);
    idle();
    chk("oe_ana", pin_oe, 8'hff);
    chk("pri_all", pin_out, 8'ha9);
    chk("blank", pi, 8'h00);
    $display("analog drive test done");
    complete_run();
  end
endmodule : testbench
